/* hw/lsrm_defines.svh */
// constants for the low supply reset monitor
`ifndef LSRM_DEFINES_SVH
`define LSRM_DEFINES_SVH
`define LSRM_ADDR_STATUS_CONTROL 4'h0
`define LSRM_ADDR_CONFIG         4'h4
`define LSRM_ADDR_IRQ_STATUS     4'h8
`define LSRM_ADDR_IRQ_MASK       4'hC
`define LSRM_BIT_FLAG            7
`define LSRM_BIT_TRIP_LEVEL_SELECT          0
`define LSRM_BIT_PWR             0
`define LSRM_BIT_RST             1
`define LSRM_BIT_EV_FLAG_SET     0
`define LSRM_BIT_EV_RESET        1
`define LSRM_CONFIG_RESET        2'h1
`define LSRM_RESET_FILTER_CYCLES 6'h09
`define LSRM_FLAG_FILTER_CYCLES  6'h24
`define LSRM_COUNT_MAX           6'h3F
`endif

/* hw/lsrm_monitor.sv */
// low supply reset monitor: filter, flag, reset request and avalon register slave
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "lsrm_defines.svh"
module lsrm_monitor
  import lsrm_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        below_trip_i,
  input  wire logic        above_recovery_i,
  input  wire logic        low_power_mode_i,
  output logic             trip_level_select_o,
  output logic             comparator_enable_o,
  output logic             chip_reset_req_o,
  output logic             reset_pin_n_o,
  output logic             reset_pin_oe_o,
  output logic             mode_wakeup_o,
  output logic             irq_o
);
  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic       below_meta;
  logic       below_sync;
  logic       above_meta;
  logic       above_sync;
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      below_meta <= 1'b0;
      below_sync <= 1'b0;
      above_meta <= 1'b0;
      above_sync <= 1'b0;
    end
    else
    begin
      below_meta <= below_trip_i;
      below_sync <= below_meta;
      above_meta <= above_recovery_i;
      above_sync <= above_meta;
    end
  end

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic       wr_ok;
  logic       rd_hold;
  logic [1:0] config_bits;
  logic       trip_sel;
  logic       low_flag;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] events;
  logic       sel_change;
  logic       power_en;
  logic       reset_en;

  // one wait state on reads so readdata is registered
  assign avs_waitrequest_o = avs_read_i & ~rd_hold;
  assign wr_ok             = avs_write_i & avs_byteenable_i[0];
  assign power_en          = config_bits[`LSRM_BIT_PWR];
  assign reset_en          = config_bits[`LSRM_BIT_RST];
  assign sel_change        = wr_ok && (avs_address_i == `LSRM_ADDR_STATUS_CONTROL)
                             && (avs_writedata_i[`LSRM_BIT_TRIP_LEVEL_SELECT] != trip_sel);

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_hold        <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      rd_hold <= avs_read_i & ~rd_hold;
      if (avs_read_i & ~rd_hold)
      begin
        case (avs_address_i)
          `LSRM_ADDR_STATUS_CONTROL:
          begin
            avs_readdata_o <= {24'h000000, low_flag, 6'h00, trip_sel};
          end
          `LSRM_ADDR_CONFIG:
          begin
            avs_readdata_o <= {30'h0, config_bits};
          end
          `LSRM_ADDR_IRQ_STATUS:
          begin
            avs_readdata_o <= {30'h0, irq_status};
          end
          `LSRM_ADDR_IRQ_MASK:
          begin
            avs_readdata_o <= {30'h0, irq_mask};
          end
          default:
          begin
            avs_readdata_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      trip_sel    <= 1'b0;
      config_bits <= `LSRM_CONFIG_RESET;
      irq_mask    <= 2'h0;
    end
    else if (wr_ok)
    begin
      case (avs_address_i)
        // flag bit of this word is read only, only the select is stored
        `LSRM_ADDR_STATUS_CONTROL:
        begin
          trip_sel <= avs_writedata_i[`LSRM_BIT_TRIP_LEVEL_SELECT];
        end
        `LSRM_ADDR_CONFIG:
        begin
          config_bits <= avs_writedata_i[1:0];
        end
        `LSRM_ADDR_IRQ_MASK:
        begin
          irq_mask <= avs_writedata_i[1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_status <= 2'h0;
    end
    else if (wr_ok && avs_address_i == `LSRM_ADDR_IRQ_STATUS)
    begin
      irq_status <= (irq_status & ~avs_writedata_i[1:0]) | events;
    end
    else
    begin
      irq_status <= irq_status | events;
    end
  end
  // status bus interrupt only, the monitor itself requests none from the cpu
  assign irq_o = |(irq_status & irq_mask);

  // ****************************************************************
  // filters
  // ****************************************************************
  logic [5:0] low_count;
  logic       filtered_trip;
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      low_count <= 6'h00;
    end
    else if (!power_en || !below_sync)
    begin
      low_count <= 6'h00;
    end
    else if (low_count != `LSRM_COUNT_MAX)
    begin
      // saturates so a long brown out cannot wrap and re-arm the filters
      low_count <= low_count + 6'h01;
    end
  end
  assign filtered_trip = (low_count >= `LSRM_RESET_FILTER_CYCLES - 6'h01)
                         && below_sync && power_en && reset_en;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      low_flag <= 1'b0;
    end
    else if (!power_en || above_sync)
    begin
      low_flag <= 1'b0;
    end
    else if (low_count >= `LSRM_FLAG_FILTER_CYCLES)
    begin
      // inside the hysteresis band neither branch fires, flag holds
      low_flag <= 1'b1;
    end
  end

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  lsrm_state_type state;
  lsrm_state_type next_state;
  logic           sel_low;
  logic           enter_rst;
  // select register, output register plus two sync stages: look once the new compare arrives
  logic [3:0]     sel_watch;
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sel_watch <= 4'h0;
    end
    else
    begin
      sel_watch <= {sel_watch[2:0], sel_change};
    end
  end
  assign sel_low   = sel_watch[3] & below_sync;
  assign enter_rst = filtered_trip | sel_low;

  always_comb
  begin
    next_state = state;
    case (state)
      LSRM_RUN:
      begin
        // filtered trip, or a select change that leaves the synced input below the new trip, enters reset
        if (enter_rst)
        begin
          next_state = LSRM_IN_RST;
        end
      end
      LSRM_IN_RST:
      begin
        // one synced sample above recovery is enough to leave
        if (above_sync)
        begin
          next_state = LSRM_RUN;
        end
      end
      default:
      begin
        next_state = LSRM_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      state <= LSRM_RUN;
    else
      state <= next_state;
  end

  assign events = {(state == LSRM_RUN) && enter_rst,
                   (low_count == `LSRM_FLAG_FILTER_CYCLES) && !above_sync};

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      chip_reset_req_o <= 1'b0;
      reset_pin_n_o    <= 1'b1;
      reset_pin_oe_o   <= 1'b0;
      mode_wakeup_o    <= 1'b0;
    end
    else
    begin
      chip_reset_req_o <= (next_state == LSRM_IN_RST);
      reset_pin_n_o    <= 1'b0;
      reset_pin_oe_o   <= (next_state == LSRM_IN_RST);
      mode_wakeup_o    <= low_power_mode_i && (next_state == LSRM_IN_RST);
    end
  end

  // comparator kept powered through wait and stop when enabled
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      comparator_enable_o <= 1'b1;
    end
    else
    begin
      comparator_enable_o <= power_en;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      trip_level_select_o <= 1'b0;
    end
    else
    begin
      trip_level_select_o <= trip_sel;
    end
  end
endmodule // lsrm_monitor

/* hw/lsrm_pkg.sv */
// types for the low supply reset monitor
package lsrm_pkg;
  typedef enum logic [1:0]
  {
    LSRM_RUN     = 2'b00,
    LSRM_IN_RST  = 2'b01
  } lsrm_state_type;
endpackage

/* testbench/lsrm_monitor_sva.sv */
// checker for the low supply reset monitor ports
`timescale 1ns/1ps
module lsrm_monitor_sva
(
  input logic clock_i,
  input logic reset_i,
  input logic avs_read_i,
  input logic avs_write_i,
  input logic avs_waitrequest_o,
  input logic below_trip_i,
  input logic above_recovery_i,
  input logic low_power_mode_i,
  input logic trip_level_select_o,
  input logic comparator_enable_o,
  input logic chip_reset_req_o,
  input logic reset_pin_n_o,
  input logic reset_pin_oe_o,
  input logic mode_wakeup_o
);
  // ******
  // properties
  // ******
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_sel_moved;
    $changed(trip_level_select_o) ##1 below_trip_i [*5];
  endsequence
  sequence s_read_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  AST_OUT_OF_RESET: assert property ($fell(reset_i) |-> comparator_enable_o
    && !trip_level_select_o) else $error("monitor state wrong after reset");
  AST_PIN_DRIVEN: assert property (chip_reset_req_o |-> reset_pin_oe_o && !reset_pin_n_o)
    else $error("reset pin not driven low");
  AST_RELEASE: assert property (chip_reset_req_o && above_recovery_i
    |-> ##[1:5] !chip_reset_req_o) else $error("reset not released");
  // sync delay gives a window, not one cycle
  AST_HOLD: assert property ($fell(chip_reset_req_o) |-> $past(above_recovery_i, 2)
    || $past(above_recovery_i, 3) || $past(above_recovery_i, 4)
    || $past(above_recovery_i, 5)) else $error("reset released while low");
  AST_WAKE: assert property ($rose(chip_reset_req_o) && low_power_mode_i
    |-> ##[0:1] mode_wakeup_o) else $error("no wakeup with reset");
  AST_SEL_CHANGE: assert property (s_sel_moved |-> ##[0:4] chip_reset_req_o)
    else $error("no reset after select change");
  AST_READ_WAIT: assert property ($rose(avs_read_i) |-> s_read_wait)
    else $error("read wait cycle wrong");
  AST_WRITE_NOWAIT: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
endmodule // lsrm_monitor_sva

bind lsrm_monitor lsrm_monitor_sva u_sva (.*);

/* testbench/lsrm_supply_model.sv */
// comparator model on the analog side of the monitor
`timescale 1ns/1ps
module lsrm_supply_model
#(
  parameter int TRIP_SET1 = 200,
  parameter int TRIP_SET2 = 100,
  parameter int HYST      = 10
)
(
  input  var int    level_i,
  input  wire logic trip_level_select_i,
  output logic      below_trip_o,
  output logic      above_recovery_o
);
  // ******
  // comparator
  // ******
  int trip;
  // select moves trip and recovery points together
  assign trip = trip_level_select_i ? TRIP_SET1 : TRIP_SET2;
  assign below_trip_o = level_i <= trip;
  assign above_recovery_o = level_i > trip + HYST;
endmodule // lsrm_supply_model

/* testbench/testbench.sv */
// self-checking bench for the low supply reset monitor
`timescale 1ns/1ps
module testbench;
  logic        clock_i = 1'h0;
  logic        reset_i = 1'h1;
  logic        avs_read_i = 1'h0;
  logic        avs_write_i = 1'h0;
  logic        low_power_mode_i = 1'h0;
  logic        seen_rst = 1'h0;
  logic [3:0]  avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, below_trip_i, above_recovery_i, trip_level_select_o;
  logic        comparator_enable_o, chip_reset_req_o, reset_pin_n_o, reset_pin_oe_o;
  logic        mode_wakeup_o, irq_o;
  int          level = 300;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          exp_cfg = 1;
  lsrm_monitor dut (.*, .avs_byteenable_i(4'hF));
  lsrm_supply_model partner (.level_i(level), .trip_level_select_i(trip_level_select_o),
    .below_trip_o(below_trip_i), .above_recovery_o(above_recovery_i));
  initial forever #2.5 clock_i = ~clock_i;
  // ******
  // helpers
  // ******
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (chip_reset_req_o === 1'h1) seen_rst <= 1'h1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // a spare edge after release keeps back to back calls from double driving
  task automatic bus(input bit we, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= we;
    avs_read_i <= !we;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'h0);
    if (!we) chk("readdata", e, avs_readdata_o);
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
    @(posedge clock_i);
  endtask
  task automatic hold(input int lv, input int n);
    level <= lv;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ******
  // tests
  // ******
  initial
  begin
    void'($urandom(20170));
    repeat (3) @(posedge clock_i);
    reset_i <= 1'h0;
    @(posedge clock_i);
    chk("cmp_en", 1'h1, comparator_enable_o);
    bus(0, 4'h0, 0, 32'h0);
    bus(0, 4'h4, 0, exp_cfg);
    bus(0, 4'h2, 0, 32'h0);
    $display("test reset_values done");
    hold(50, 25);
    bus(0, 4'h0, 0, 32'h0);
    hold(50, 20);
    bus(0, 4'h0, 0, 32'h80);
    chk("irq", 1'h0, irq_o);
    bus(1, 4'hC, 1, 0);
    chk("irq", 1'h1, irq_o);
    hold(105, 10);
    bus(0, 4'h0, 0, 32'h80);
    hold(300, 6);
    bus(0, 4'h0, 0, 32'h0);
    bus(1, 4'h8, 1, 0);
    chk("irq", 1'h0, irq_o);
    chk("seen_rst", 1'h0, seen_rst);
    $display("test polled done");
    exp_cfg = 3;
    bus(1, 4'h4, exp_cfg, 0);
    bus(0, 4'h4, 0, exp_cfg);
    repeat (4)
    begin
      hold(50, 1 + $urandom % 8);
      hold(300, 1);
    end
    hold(300, 4);
    chk("seen_rst", 1'h0, seen_rst);
    low_power_mode_i <= 1'h1;
    hold(50, 9);
    hold(105, 12);
    chk("req", 1'h1, chip_reset_req_o);
    chk("pin_oe", 1'h1, reset_pin_oe_o);
    chk("wake", 1'h1, mode_wakeup_o);
    hold(300, 6);
    chk("req", 1'h0, chip_reset_req_o);
    bus(0, 4'h8, 0, 32'h2);
    bus(1, 4'h8, 3, 0);
    low_power_mode_i <= 1'h0;
    $display("test forced done");
    bus(1, 4'h4, 2, 0);
    @(posedge clock_i);
    chk("cmp_en", 1'h0, comparator_enable_o);
    seen_rst <= 1'h0;
    hold(50, 20);
    hold(300, 4);
    chk("seen_rst", 1'h0, seen_rst);
    $display("test no_power done");
    bus(1, 4'h4, 0, 0);
    hold(150, 4);
    bus(1, 4'h0, 1, 0);
    hold(150, 8);
    chk("req", 1'h1, chip_reset_req_o);
    chk("sel", 1'h1, trip_level_select_o);
    bus(0, 4'h0, 0, 32'h1);
    hold(300, 6);
    chk("req", 1'h0, chip_reset_req_o);
    $display("test select done");
    stop_test();
  end
endmodule // testbench
